// ==== logic/mpps_pkg.sv ====
//==============================================================
// Contract
// - each pin has a mode field, a select code and a data value held in control settings.
// - mode 0 select 0 is the default and makes the pin an input that is captured.
// - mode 0 selects 1 to 4 drive capture strobe, id nibbles low and high, mux-out bits 15:12.
// - mode 0 select 8 drives the display-path strobe flag.
// - mode 0 select 14 drives zero followed by embedded H, V and F flags.
// - mode 0 select 15 drives encoder hsync, vsync, field and link.
// - mode 1 select 0 drives the data value, select 1 samples the pin.
// - mode 2 selects 0 to 2 drive decoder H, V and field sync of inputs 3 down to 0.
// - mode 2 selects 3 to 6 drive decoder channel data nibbles.
// - mode 2 selects 8 to 11 drive primary input loss, motion, blind, night.
// - mode 2 selects 12 to 15 drive secondary input loss, motion, blind, night.
// - record video can leave on record pin group a, with its own clock.
// - record video is timed to its clock whose rate and phase are set per path.
// - per-channel detection status can appear on any of the three pins.
//==============================================================
package mpps_pkg;
   localparam int          PIN_W     = 4;
   localparam int          NUM_PINS  = 3;
   localparam logic [1:0]  MODE_RST  = 2'h0;
   localparam logic [3:0]  SEL_RST   = 4'h0;
   localparam logic [3:0]  DATA_RST  = 4'h0;
   localparam logic [1:0]  MODE_STAT = 2'h0;
   localparam logic [1:0]  MODE_GPIO = 2'h1;
   localparam logic [1:0]  MODE_DEC  = 2'h2;
   localparam int          FIFO_DEPTH = 4;

   typedef struct packed {
      logic [1:0] mode;
      logic [3:0] sel;
      logic [3:0] data;
   } mpps_cfg_t;

   typedef struct packed {
      logic       strobe_cap;
      logic       strobe_disp;
      logic [7:0] channel_id_mux_value;
      logic [3:0] mux_out_hi;
      logic [2:0] emb_hvf;
      logic [3:0] enc_sync;
      logic [3:0] dec_hs;
      logic [3:0] dec_vs;
      logic [3:0] dec_fs;
      logic [7:0] dec_ch01;
      logic [7:0] dec_ch23;
      logic [3:0] pri_loss;
      logic [3:0] primary_motion_detect;
      logic [3:0] primary_blind_detect;
      logic [3:0] primary_night_detect;
      logic [3:0] sec_loss;
      logic [3:0] secondary_motion_detect;
      logic [3:0] secondary_blind_detect;
      logic [3:0] secondary_night_detect;
   } mpps_stat_t;
endpackage

// ==== logic/mpps_fifo.sv ====
//==============================================================
// fifo between core and record link
module mpps_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // write side, clock wr_clk
   input  wire logic             wr_clk,
   input  wire logic             wr_rst,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   input  wire logic [WIDTH-1:0] wr_data,
   // read side, clock rd_clk
   input  wire logic             rd_clk,
   input  wire logic             rd_rst,
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic [WIDTH-1:0]      rd_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wbin_r, wbin_nxt, wgray_r, wgray_nxt;
   logic [AW:0]      rbin_r, rbin_nxt, rgray_r, rgray_nxt;
   logic [AW:0]      rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
   logic             wr_fire, rd_fire;

   // full and empty from synchronised gray pointers
   assign wr_ready = (wgray_r != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
   assign rd_valid = (rgray_r != wg_s2_r);
   assign wr_fire  = wr_valid & wr_ready;
   assign rd_fire  = rd_valid & rd_ready;
   assign rd_data  = mem[rbin_r[AW-1:0]];

   // pointer next values
   always_comb begin
      wbin_nxt  = wbin_r + (AW+1)'(wr_fire);
      wgray_nxt = wbin_nxt ^ (wbin_nxt >> 1);
      rbin_nxt  = rbin_r + (AW+1)'(rd_fire);
      rgray_nxt = rbin_nxt ^ (rbin_nxt >> 1);
   end

   // write domain
   always_ff @(posedge wr_clk) begin
      if (wr_fire) begin
         mem[wbin_r[AW-1:0]] <= wr_data;
      end
      if (wr_rst) begin
         wbin_r  <= '0;
         wgray_r <= '0;
         rg_s1_r <= '0;
         rg_s2_r <= '0;
      end else begin
         wbin_r  <= wbin_nxt;
         wgray_r <= wgray_nxt;
         rg_s1_r <= rgray_r;
         rg_s2_r <= rg_s1_r;
      end
   end

   // read domain
   always_ff @(posedge rd_clk) begin
      if (rd_rst) begin
         rbin_r  <= '0;
         rgray_r <= '0;
         wg_s1_r <= '0;
         wg_s2_r <= '0;
      end else begin
         rbin_r  <= rbin_nxt;
         rgray_r <= rgray_nxt;
         wg_s1_r <= wgray_r;
         wg_s2_r <= wg_s1_r;
      end
   end
endmodule

// ==== logic/mpps_top.sv ====
//==============================================================
// multi-purpose pin selector
module mpps_top
   import mpps_pkg::*;
#(
   parameter int REC_W = 8
) (
   // core clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // per-pin configuration
   input  wire mpps_cfg_t [NUM_PINS-1:0] pin_cfg,
   input  wire logic                  analog_input_switch,
   // internal status
   input  wire mpps_stat_t            stat,
   // pins
   input  wire logic [NUM_PINS-1:0][PIN_W-1:0] pin_in,
   output logic [NUM_PINS-1:0][PIN_W-1:0]      pin_out,
   output logic [NUM_PINS-1:0]                 pin_oe,
   output logic [NUM_PINS-1:0][PIN_W-1:0]      pin_capture,
   // record video source
   input  wire logic                  rec_enable,
   input  wire logic                  rec_valid,
   output logic                       rec_ready,
   input  wire logic [REC_W-1:0]      rec_data,
   input  wire logic [1:0]            record_clk_freq_a,
   input  wire logic [1:0]            record_clk_phase_a,
   // record link
   input  wire logic                  link_clk,
   input  wire logic                  link_rst,
   output logic [REC_W-1:0]           record_pin_group_a,
   output logic                       record_clock_a
);
   //==============================================================
   // pin drive and capture, one per pin
   logic [NUM_PINS-1:0][PIN_W-1:0] out_nxt, out_r, s1_r, s2_r, cap_nxt, cap_r;
   logic [NUM_PINS-1:0]            oe_nxt, oe_r;

   always_comb begin
      for (int p = 0; p < NUM_PINS; p++) begin
         out_nxt[p] = 4'h0;
         oe_nxt[p]  = 1'b1;
         cap_nxt[p] = cap_r[p];
         unique case (pin_cfg[p].mode)
            MODE_STAT: begin
               unique case (pin_cfg[p].sel)
                  4'h0: begin
                     oe_nxt[p]  = 1'b0;
                     cap_nxt[p] = s2_r[p];
                  end
                  4'h1: out_nxt[p] = {3'h0, stat.strobe_cap};
                  4'h2: out_nxt[p] = stat.channel_id_mux_value[3:0];
                  4'h3: out_nxt[p] = stat.channel_id_mux_value[7:4];
                  4'h4: out_nxt[p] = stat.mux_out_hi;
                  4'h8: out_nxt[p] = {3'h0, stat.strobe_disp};
                  4'he: out_nxt[p] = {1'b0, stat.emb_hvf};
                  4'hf: out_nxt[p] = stat.enc_sync;
                  default: out_nxt[p] = 4'h0; // reserved
               endcase
            end
            MODE_GPIO: begin
               if (pin_cfg[p].sel == 4'h0) begin
                  out_nxt[p] = pin_cfg[p].data;
               end else begin
                  oe_nxt[p]  = 1'b0;
                  cap_nxt[p] = s2_r[p];
               end
            end
            MODE_DEC: begin
               unique case (pin_cfg[p].sel)
                  4'h0: out_nxt[p] = stat.dec_hs;
                  4'h1: out_nxt[p] = stat.dec_vs;
                  4'h2: out_nxt[p] = stat.dec_fs;
                  4'h3: out_nxt[p] = stat.dec_ch01[7:4];
                  4'h4: out_nxt[p] = stat.dec_ch01[3:0];
                  4'h5: out_nxt[p] = stat.dec_ch23[7:4];
                  4'h6: out_nxt[p] = stat.dec_ch23[3:0];
                  4'h8: out_nxt[p] = stat.pri_loss;
                  4'h9: out_nxt[p] = stat.primary_motion_detect;
                  4'ha: out_nxt[p] = stat.primary_blind_detect;
                  4'hb: out_nxt[p] = stat.primary_night_detect;
                  4'hc: out_nxt[p] = stat.sec_loss;
                  4'hd: out_nxt[p] = stat.secondary_motion_detect;
                  4'he: out_nxt[p] = stat.secondary_blind_detect;
                  4'hf: out_nxt[p] = stat.secondary_night_detect;
                  default: out_nxt[p] = 4'h0; // reserved
               endcase
            end
            default: begin
               oe_nxt[p] = 1'b0;
            end
         endcase
      end
   end

   // registered pins, change shows one cycle after config
   always_ff @(posedge clk) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      if (rst) begin
         out_r <= '0;
         oe_r  <= '0;
         cap_r <= '0;
      end else begin
         out_r <= out_nxt;
         oe_r  <= oe_nxt;
         cap_r <= cap_nxt;
      end
   end

   assign pin_out     = out_r;
   assign pin_oe      = oe_r;
   assign pin_capture = cap_r;

   //==============================================================
   // record video path through fifo
   logic             f_valid, f_ready, f_in_valid, f_in_ready;
   logic [REC_W-1:0] f_data;

   assign f_in_valid = rec_valid & rec_enable;
   assign rec_ready  = f_in_ready & rec_enable;

   mpps_fifo #(.WIDTH(REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .wr_clk   (clk),
      .wr_rst   (rst),
      .wr_valid (f_in_valid),
      .wr_ready (f_in_ready),
      .wr_data  (rec_data),
      .rd_clk   (link_clk),
      .rd_rst   (link_rst),
      .rd_valid (f_valid),
      .rd_ready (f_ready),
      .rd_data  (f_data)
   );

   //==============================================================
   // link side: clock divider and data launch
   logic [2:0]       div_r, div_nxt;
   logic             ck_r, ck_nxt;
   logic [REC_W-1:0] dat_r, dat_nxt;
   logic [2:0]       half;
   logic [1:0]       freq_s1_r, freq_s2_r;
   logic             ph_s1_r, ph_s2_r;

   // rate and phase settings come from the core domain, two flops each
   always_ff @(posedge link_clk) begin
      freq_s1_r <= record_clk_freq_a;
      freq_s2_r <= freq_s1_r;
      ph_s1_r   <= record_clk_phase_a[0];
      ph_s2_r   <= ph_s1_r;
   end

   // reload value: half period of 2^f link cycles, minus one
   assign half    = 3'((4'h1 << freq_s2_r) - 4'h1);
   assign f_ready = (div_r == 3'h0) & ~ck_r; // launch with rising edge

   always_comb begin
      div_nxt = div_r - 3'h1;
      ck_nxt  = ck_r;
      dat_nxt = dat_r;
      if (div_r == 3'h0) begin
         div_nxt = half;
         ck_nxt  = ~ck_r;
         if (f_valid & f_ready) begin
            dat_nxt = f_data;
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         div_r <= 3'h0;
         ck_r  <= 1'b0;
         dat_r <= '0;
      end else begin
         div_r <= div_nxt;
         ck_r  <= ck_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign record_pin_group_a = dat_r;
   assign record_clock_a     = ck_r ^ ph_s2_r;
endmodule

// ==== tb/mpps_checker.sv ====
//====================
// pin drive checker
module mpps_checker
   import mpps_pkg::*;
(
   // clock and reset
   input wire logic                           clk,
   input wire logic                           rst,
   // configuration and status
   input wire mpps_cfg_t [NUM_PINS-1:0]       pin_cfg,
   input wire mpps_stat_t                     stat,
   // pin drive
   input wire logic [NUM_PINS-1:0][PIN_W-1:0] pin_out,
   input wire logic [NUM_PINS-1:0]            pin_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   // mode and select of pins 0 and 1
   wire logic [5:0] c0 = {pin_cfg[0].mode, pin_cfg[0].sel};
   wire logic [5:0] c1 = {pin_cfg[1].mode, pin_cfg[1].sel};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_cap_strobe: assert property (c0 == 6'h01 |=>
      pin_out[0] == {3'h0, $past(stat.strobe_cap)} && pin_oe[0]) else $error("bad strobe");
   a_disp_strobe: assert property (c1 == 6'h08 |=>
      pin_out[1] == {3'h0, $past(stat.strobe_disp)}) else $error("bad disp strobe");
   a_emb_sync: assert property (c0 == 6'h0e |=>
      pin_out[0] == {1'b0, $past(stat.emb_hvf)}) else $error("bad embedded sync");
   a_enc_sync: assert property (c1 == 6'h0f |=>
      pin_out[1] == $past(stat.enc_sync)) else $error("bad encoder sync");
   a_gpio_drive: assert property (c0 == 6'h10 |=>
      pin_out[0] == $past(pin_cfg[0].data) && pin_oe[0]) else $error("bad gpio drive");
   a_input_float: assert property (c0 == 6'h00 |=> !pin_oe[0])
      else $error("input pin driven");
   a_dec_hsync: assert property (c1 == 6'h20 |=>
      pin_out[1] == $past(stat.dec_hs)) else $error("bad decoder hsync");
   a_pri_motion: assert property (c0 == 6'h29 |=>
      pin_out[0] == $past(stat.primary_motion_detect)) else $error("bad motion");
   a_sec_night: assert property (c1 == 6'h2f |=>
      pin_out[1] == $past(stat.secondary_night_detect)) else $error("bad night");
endmodule

bind mpps_top mpps_checker mpps_checker_i (.clk, .rst, .pin_cfg, .stat, .pin_out, .pin_oe);

// ==== tb/mpps_rec_sink.sv ====
//====================
// record pin receiver
module mpps_rec_sink (
   // link reset
   input wire logic       link_rst,
   // clock polarity setting
   input wire logic       phase,
   // record pins
   input wire logic [7:0] group_in,
   input wire logic       clk_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] words [$];
   logic [7:0] last_r   = 8'h00;
   time        rise_t   = 0;
   time        period_t = 0;
   // data moves on the launching clock edge, so take it mid-period
   always @(negedge (clk_in ^ phase)) begin
      if (!link_rst && group_in !== last_r) begin
         words.push_back(group_in);
         last_r = group_in;
      end
   end
   // time between launching edges, for the rate check
   always @(posedge (clk_in ^ phase)) begin
      period_t = $time - rise_t;
      rise_t   = $time;
   end
endmodule

// ==== tb/multi_purpose_pin_selector_test.sv ====
//====================
// pin selector bench
module multi_purpose_pin_selector_test import mpps_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic                           clk = 0, rst = 1, link_clk = 0, link_rst = 1;
   mpps_cfg_t [NUM_PINS-1:0]       cfg;
   mpps_stat_t                     st;
   logic [NUM_PINS-1:0][PIN_W-1:0] pin_in, pin_out, pin_cap;
   logic [NUM_PINS-1:0]            pin_oe;
   logic                           sw, rec_en, rec_valid, rec_ready, rclk;
   logic [1:0]                     rfreq, rphase;
   logic [7:0]                     rec_data, rgrp;
   int                             n_mismatch = 0, check_count = 0;
   localparam logic [5:0] CODES [23] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h0e, 6'h0f,
      6'h10, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h28, 6'h29, 6'h2a, 6'h2b,
      6'h2c, 6'h2d, 6'h2e, 6'h2f};

   mpps_top #(.REC_W(8)) mpps_top_i (.clk(clk), .rst(rst), .pin_cfg(cfg),
      .analog_input_switch(sw), .stat(st), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_capture(pin_cap), .rec_enable(rec_en), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .rec_data(rec_data), .record_clk_freq_a(rfreq),
      .record_clk_phase_a(rphase), .link_clk(link_clk), .link_rst(link_rst),
      .record_pin_group_a(rgrp), .record_clock_a(rclk));
   mpps_rec_sink mpps_rec_sink_i (.link_rst(link_rst), .group_in(rgrp), .clk_in(rclk),
      .phase(rphase[0]));

   //====================
   // clocks and watchdog
   initial forever #20 clk = ~clk;
   initial begin
      #7;
      forever #32 link_clk = ~link_clk;
   end
   initial begin
      #(3000 * 40); // tests need about 800 cycles
      n_mismatch++;
      report_and_stop;
   end

   //====================
   // helpers
   task automatic check(string what, logic [15:0] seen, logic [15:0] want);
      check_count++;
      if (seen !== want) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, want, seen);
      end
   endtask
   function automatic logic [3:0] exp_out(logic [5:0] c, logic [3:0] d);
      case (c)
         6'h01: return {3'h0, st.strobe_cap};
         6'h02: return st.channel_id_mux_value[3:0];
         6'h03: return st.channel_id_mux_value[7:4];
         6'h04: return st.mux_out_hi;
         6'h08: return {3'h0, st.strobe_disp};
         6'h0e: return {1'b0, st.emb_hvf};
         6'h0f: return st.enc_sync;
         6'h10: return d;
         6'h20: return st.dec_hs;
         6'h21: return st.dec_vs;
         6'h22: return st.dec_fs;
         6'h23: return st.dec_ch01[7:4];
         6'h24: return st.dec_ch01[3:0];
         6'h25: return st.dec_ch23[7:4];
         6'h26: return st.dec_ch23[3:0];
         6'h28: return st.pri_loss;
         6'h29: return st.primary_motion_detect;
         6'h2a: return st.primary_blind_detect;
         6'h2b: return st.primary_night_detect;
         6'h2c: return st.sec_loss;
         6'h2d: return st.secondary_motion_detect;
         6'h2e: return st.secondary_blind_detect;
         6'h2f: return st.secondary_night_detect;
         default: return 4'h0;
      endcase
   endfunction

   //====================
   // scenarios
   task automatic t_reset;
      check("enables after reset", pin_oe, 3'h0);
      check("capture after reset", pin_cap, 12'h000);
      check("drive after reset", pin_out, 12'h000);
      $display("done reset");
   endtask
   task automatic t_table;
      int p, k;
      logic [5:0] c;
      for (int i = 0; i < $bits(st); i++) st[i] = (i % 3 == 0) ^ (i % 7 == 2);
      sw = 1;
      for (k = 0; k < 23; k++) begin
         for (p = 0; p < NUM_PINS; p++) begin
            c = CODES[(k + p * 5) % 23];
            cfg[p] = '{c[5:4], c[3:0], 4'hb - p[3:0]};
         end
         @(negedge clk);
         for (p = 0; p < NUM_PINS; p++) begin
            c = CODES[(k + p * 5) % 23];
            check("pin drive", pin_out[p], exp_out(c, 4'hb - p[3:0]));
            check("pin enable", pin_oe[p], 1'b1);
         end
      end
      $display("done table");
   endtask
   task automatic t_input;
      cfg[0] = '{MODE_STAT, 4'h0, 4'h0};
      cfg[1] = '{MODE_GPIO, 4'h1, 4'h0};
      cfg[2] = '{MODE_GPIO, 4'h1, 4'h0};
      @(negedge clk);
      pin_in = {4'h6, 4'h9, 4'hc};
      repeat (3) @(negedge clk);
      check("captured", pin_cap, 12'h69c);
      check("input enables", pin_oe, 3'h0);
      cfg[0] = '{MODE_STAT, 4'h1, 4'h0};
      cfg[2] = '{MODE_GPIO, 4'h0, 4'h5};
      pin_in[0] = 4'h3;
      repeat (4) @(negedge clk);
      check("held capture", pin_cap[0], 4'hc);
      check("gpio drive", pin_out[2], 4'h5);
      check("gpio enable", pin_oe[2], 1'b1);
      // mode 3 is not a drive mode, the pin floats
      cfg[2] = '{2'h3, 4'h0, 4'h5};
      @(negedge clk);
      check("mode 3 enable", pin_oe[2], 1'b0);
      check("mode 3 drive", pin_out[2], 4'h0);
      $display("done input");
   endtask
   task automatic t_record(logic [1:0] f, logic [1:0] ph, logic [7:0] base);
      int i, stalls;
      stalls = 0;
      rfreq = f;
      rphase = ph;
      mpps_rec_sink_i.words.delete();
      rec_en = 1;
      repeat (8) @(negedge clk); // let the new settings cross
      for (i = 0; i < 8; i++) begin
         rec_valid = 1;
         rec_data = 8'(base * (i + 1));
         while (rec_ready !== 1'b1) begin
            stalls++;
            @(negedge clk);
         end
         @(negedge clk);
      end
      rec_valid = 0;
      repeat (300) @(negedge clk);
      check("fifo refused", 16'(stalls > 0), 16'h1);
      check("word count", 16'(mpps_rec_sink_i.words.size()), 16'h8);
      foreach (mpps_rec_sink_i.words[j])
         check("record word", mpps_rec_sink_i.words[j], 8'(base * (j + 1)));
      // full period is two halves of 2^f link cycles of 64 ns
      check("record clock period", 16'(mpps_rec_sink_i.period_t), 16'(128 << f));
      $display("done record");
   endtask

   //====================
   // main sequence and verdict
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      cfg = '0;
      st = '0;
      pin_in = '0;
      sw = 0;
      rec_en = 0;
      rec_valid = 0;
      rec_data = 8'h00;
      rfreq = 2'h3;
      rphase = 2'h0;
      repeat (4) @(negedge clk);
      rst = 0;
      link_rst = 0;
      t_reset;
      t_table;
      t_input;
      t_record(2'h3, 2'h0, 8'h11);
      t_record(2'h0, 2'h1, 8'h13);
      report_and_stop;
   end
endmodule
